// ---- hdl/agc_defs.svh ----
// constants for the gain, bias and agc control register bank
// assumes a 16-bit register port with 8-bit addresses
`ifndef AGC_DEFS_SVH
`define AGC_DEFS_SVH
`define AGC_OFS_FRAC      8'h1c
`define AGC_OFS_STEP      8'h1d
`define AGC_OFS_HGAIN     8'h1e
`define AGC_FRAC_MAX      14'd9999
`define AGC_FRAC_LSB      2
`define AGC_STEP_RST      5'h00
`define AGC_HGAIN_RST     16'hff00
`define AGC_HALF_DB_STEP  8'h01
`define AGC_BUZ_STEP      4'h1
`define AGC_GAIN_MIN      8'he8
`define AGC_GAIN_MAX      8'h77
`endif

// ---- hdl/agc_pkg.sv ----
// types for the gain, bias and agc control register bank
// assumes agc_defs.svh is compiled alongside
`default_nettype none
package agc_pkg;
	typedef struct packed {
		logic        write;
		logic        read;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} agc_req_t;
	typedef enum logic [1:0] {
		agc_hys_1db  = 2'b00,
		agc_hys_2db  = 2'b01,
		agc_hys_4db  = 2'b10,
		agc_hys_none = 2'b11
	} agc_hys_t;
	typedef enum logic [1:0] {
		agc_bias_3v3 = 2'b00,
		agc_bias_2v5 = 2'b01,
		agc_bias_2v0 = 2'b10
	} agc_bias_t;
endpackage
`default_nettype wire

// ---- hdl/agc_regs.sv ----
// register bank: clock-loop fraction, soft-step, bias, handset gain and agc
// assumes a synchronous register port and a one-cycle fs_tick at the reference sample rate
`include "agc_defs.svh"
`default_nettype none
module agc_regs (
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire agc_pkg::agc_req_t req,
	output logic [15:0]           rdata,
	output logic                  rvalid,
	input  wire logic             clock_loop_enable,
	input  wire logic             fs_tick,
	input  wire logic             short_detect,
	input  wire logic             handset_selected,
	input  wire logic [7:0]       agc_gain_code,
	input  wire logic [7:0]       sidetone_target,
	input  wire logic [7:0]       cellphone_target,
	input  wire logic [3:0]       buzzer_target,
	output logic [13:0]           pll_fraction_applied,
	output logic                  mic_gain_step_disable,
	output logic                  conv_out_gain_step_disable,
	output logic [7:0]            sidetone_gain_applied,
	output logic [7:0]            cellphone_gain_applied,
	output logic [3:0]            buzzer_gain_applied,
	output logic [2:0]            agc_hysteresis_db,
	output logic                  agc_hysteresis_on,
	output agc_pkg::agc_bias_t    headset_bias_output,
	output logic                  handset_bias_output,
	output logic                  handset_input_mute,
	output logic [6:0]            handset_input_gain,
	output logic [2:0]            handset_agc_target,
	output logic [3:0]            handset_agc_timing,
	output logic                  handset_agc_enable
);

	// --------------------------------------------------------------
	// register storage
	// --------------------------------------------------------------
	logic [13:0] pll_fraction;
	logic [4:0]  step_dis;
	logic [1:0]  agc_hysteresis_sel;
	logic [1:0]  headset_bias_sel;
	logic        handset_bias_sel;
	logic        short_circuit_flag;
	logic [15:0] hgain;
	logic        wr_frac;
	logic        wr_step;
	logic        wr_hgain;
	logic [15:0] next_rdata;
	logic        agc_drives;

	assign wr_frac  = req.write && (req.addr == `AGC_OFS_FRAC);
	assign wr_step  = req.write && (req.addr == `AGC_OFS_STEP);
	assign wr_hgain = req.write && (req.addr == `AGC_OFS_HGAIN);
	assign agc_drives = hgain[0] && handset_selected;

	always_ff @(posedge mclk) begin
		if (reset) begin
			pll_fraction <= 14'h0000;
		end else if (wr_frac) begin
			// clamp at write so readback shows the value in use
			if (req.wdata[15:2] > `AGC_FRAC_MAX) begin
				pll_fraction <= `AGC_FRAC_MAX;
			end else begin
				pll_fraction <= req.wdata[15:2];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			step_dis           <= `AGC_STEP_RST;
			agc_hysteresis_sel <= 2'h0;
			headset_bias_sel   <= 2'h0;
			handset_bias_sel   <= 1'h0;
		end else if (wr_step) begin
			step_dis           <= req.wdata[15:11];
			agc_hysteresis_sel <= req.wdata[10:9];
			headset_bias_sel   <= req.wdata[8:7];
			handset_bias_sel   <= req.wdata[6];
		end
	end

	// follows the detector one cycle late, so software sees the live state
	always_ff @(posedge mclk) begin
		if (reset) begin
			short_circuit_flag <= 1'h0;
		end else begin
			short_circuit_flag <= short_detect;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			hgain <= `AGC_HGAIN_RST;
		end else if (wr_hgain) begin
			hgain <= req.wdata;
		end
	end

	// --------------------------------------------------------------
	// read port
	// --------------------------------------------------------------
	always_comb begin
		next_rdata = 16'h0000;
		case (req.addr)
			`AGC_OFS_FRAC: begin
				next_rdata = {pll_fraction, 2'h0};
			end
			`AGC_OFS_STEP: begin
				next_rdata = {step_dis, agc_hysteresis_sel, headset_bias_sel, handset_bias_sel,
					4'h0, short_circuit_flag, 1'h0};
			end
			`AGC_OFS_HGAIN: begin
				if (agc_drives) begin
					next_rdata = {agc_gain_code, hgain[7:0]};
				end else begin
					next_rdata = hgain;
				end
			end
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata  <= 16'h0000;
			rvalid <= 1'h0;
		end else begin
			rdata  <= req.read ? next_rdata : 16'h0000;
			rvalid <= req.read;
		end
	end

	// --------------------------------------------------------------
	// clock loop fraction
	// --------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			pll_fraction_applied <= 14'h0000;
		end else begin
			pll_fraction_applied <= clock_loop_enable ? pll_fraction : 14'h0000;
		end
	end

	// --------------------------------------------------------------
	// soft stepping; gains are codes, one lsb per documented step
	// --------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			sidetone_gain_applied <= 8'h00;
		end else if (step_dis[2]) begin
			sidetone_gain_applied <= sidetone_target;
		end else if (fs_tick && sidetone_gain_applied < sidetone_target) begin
			sidetone_gain_applied <= sidetone_gain_applied + `AGC_HALF_DB_STEP;
		end else if (fs_tick && sidetone_gain_applied > sidetone_target) begin
			sidetone_gain_applied <= sidetone_gain_applied - `AGC_HALF_DB_STEP;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			cellphone_gain_applied <= 8'h00;
		end else if (step_dis[1]) begin
			cellphone_gain_applied <= cellphone_target;
		end else if (fs_tick && cellphone_gain_applied < cellphone_target) begin
			cellphone_gain_applied <= cellphone_gain_applied + `AGC_HALF_DB_STEP;
		end else if (fs_tick && cellphone_gain_applied > cellphone_target) begin
			cellphone_gain_applied <= cellphone_gain_applied - `AGC_HALF_DB_STEP;
		end
	end

	// buzzer code lsb is 3 dB, so one code per tick
	always_ff @(posedge mclk) begin
		if (reset) begin
			buzzer_gain_applied <= 4'h0;
		end else if (step_dis[0]) begin
			buzzer_gain_applied <= buzzer_target;
		end else if (fs_tick && buzzer_gain_applied < buzzer_target) begin
			buzzer_gain_applied <= buzzer_gain_applied + `AGC_BUZ_STEP;
		end else if (fs_tick && buzzer_gain_applied > buzzer_target) begin
			buzzer_gain_applied <= buzzer_gain_applied - `AGC_BUZ_STEP;
		end
	end

	// --------------------------------------------------------------
	// decoded controls toward the analog and agc blocks
	// --------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			mic_gain_step_disable      <= 1'h0;
			conv_out_gain_step_disable <= 1'h0;
		end else begin
			mic_gain_step_disable      <= step_dis[4];
			conv_out_gain_step_disable <= step_dis[3];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			agc_hysteresis_db <= 3'h1;
		end else begin
			case (agc_hysteresis_sel)
				agc_pkg::agc_hys_1db: begin
					agc_hysteresis_db <= 3'h1;
				end
				agc_pkg::agc_hys_2db: begin
					agc_hysteresis_db <= 3'h2;
				end
				agc_pkg::agc_hys_4db: begin
					agc_hysteresis_db <= 3'h4;
				end
				default: begin
					agc_hysteresis_db <= 3'h0;
				end
			endcase
		end
	end

	// hysteresis only matters while the agc owns the handset gain
	always_ff @(posedge mclk) begin
		if (reset) begin
			agc_hysteresis_on <= 1'h0;
		end else begin
			agc_hysteresis_on <= (agc_hysteresis_sel != agc_pkg::agc_hys_none) && agc_drives;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			headset_bias_output <= agc_pkg::agc_bias_3v3;
		end else begin
			case (headset_bias_sel)
				2'b00: begin
					headset_bias_output <= agc_pkg::agc_bias_3v3;
				end
				2'b01: begin
					headset_bias_output <= agc_pkg::agc_bias_2v5;
				end
				default: begin
					headset_bias_output <= agc_pkg::agc_bias_2v0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			handset_bias_output <= 1'h0;
		end else begin
			handset_bias_output <= handset_bias_sel;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			handset_input_mute <= 1'h1;
			handset_input_gain <= 7'h7f;
		end else begin
			// while agc is enabled the mute is forced off; the manual gain field still drives handset_input_gain
			handset_input_mute <= hgain[0] ? 1'h0 : hgain[15];
			handset_input_gain <= hgain[14:8];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			handset_agc_target <= 3'h0;
			handset_agc_timing <= 4'h0;
			handset_agc_enable <= 1'h0;
		end else begin
			handset_agc_target <= hgain[7:5];
			handset_agc_timing <= hgain[4:1];
			handset_agc_enable <= hgain[0];
		end
	end

endmodule
`default_nettype wire

// ---- sim/agc_host.sv ----
// host model: register writes and reads on the request port
// assumes one call at a time, each strobe one cycle long
`default_nettype none
module agc_host (
	input wire logic             mclk,
	output var agc_pkg::agc_req_t req
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// bus cycles
	// ----
	initial req = '0;
	// raw lets a scenario set reserved bits on purpose
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input bit raw);
		if (!raw)
			d &= (a == 8'h1c) ? 16'hfffc : (a == 8'h1d) ? 16'hffc0 : 16'hffff;
		@(posedge mclk) req <= {1'b1, 1'b0, a, d};
		@(posedge mclk) req <= '0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk) req <= {1'b0, 1'b1, a, 16'h0000};
		@(posedge mclk) req <= '0;
	endtask
endmodule
`default_nettype wire

// ---- sim/agc_regs_asserts.sv ----
// port checker for the agc register bank
// assumes the bind below reaches every agc_regs instance
`default_nettype none
module agc_regs_asserts (
	input wire logic               mclk,
	input wire logic               reset,
	input wire agc_pkg::agc_req_t  req,
	input wire logic [15:0]        rdata,
	input wire logic               rvalid,
	input wire logic               clock_loop_enable,
	input wire logic               fs_tick,
	input wire logic [7:0]         sidetone_target,
	input wire logic [3:0]         buzzer_target,
	input wire logic [13:0]        pll_fraction_applied,
	input wire logic [7:0]         sidetone_gain_applied,
	input wire logic [3:0]         buzzer_gain_applied,
	input wire logic [2:0]         agc_hysteresis_db,
	input wire agc_pkg::agc_bias_t headset_bias_output,
	input wire logic [2:0]         handset_agc_target,
	input wire logic [3:0]         handset_agc_timing
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// checks
	// ----
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	a_frac_gate: assert property (!$past(clock_loop_enable) |-> pll_fraction_applied == 14'h0000)
		else $error("fraction applied while loop off");
	a_frac_low: assert property (rvalid && $past(req.addr) == 8'h1c |-> rdata[1:0] == 2'h0)
		else $error("fraction low bits not zero");
	a_ctl_resv: assert property (rvalid && $past(req.addr) == 8'h1d |-> rdata[5:2] == 4'h0 && !rdata[0])
		else $error("reserved control bits not zero");
	// a change without a tick is only legal as a jump straight to the target
	a_side_hold: assert property (!$past(fs_tick) && $changed(sidetone_gain_applied) |->
		sidetone_gain_applied == $past(sidetone_target)) else $error("sidetone gain moved off tick");
	a_buz_hold: assert property (!$past(fs_tick) && $changed(buzzer_gain_applied) |->
		buzzer_gain_applied == $past(buzzer_target)) else $error("buzzer gain moved off tick");
	a_hys_decode: assert property (req.write && req.addr == 8'h1d |=> ##1 agc_hysteresis_db ==
		($past(req.wdata[10:9], 2) == 2'h3 ? 3'h0 : 3'h1 << $past(req.wdata[10:9], 2)))
		else $error("hysteresis decode wrong");
	a_bias_sel: assert property (req.write && req.addr == 8'h1d |=> ##1 headset_bias_output ==
		($past(req.wdata[8], 2) ? 2'h2 : $past(req.wdata[8:7], 2))) else $error("headset bias wrong");
	a_agc_field: assert property (req.write && req.addr == 8'h1e |=> ##1
		{handset_agc_target, handset_agc_timing} == $past(req.wdata[7:1], 2)) else $error("agc fields wrong");
	c_step: cover property ($changed(buzzer_gain_applied));
	c_short: cover property (rvalid && rdata[1]);
	c_clamp: cover property (pll_fraction_applied == 14'd9999);
endmodule
bind agc_regs agc_regs_asserts agc_regs_asserts_inst (.mclk, .reset, .req, .rdata, .rvalid, .clock_loop_enable,
	.fs_tick, .sidetone_target, .buzzer_target, .pll_fraction_applied, .sidetone_gain_applied,
	.buzzer_gain_applied, .agc_hysteresis_db, .headset_bias_output, .handset_agc_target, .handset_agc_timing);
`default_nettype wire

// ---- sim/agc_regs_bench.sv ----
// self-checking bench for the agc register bank
// assumes agc_host drives requests and the checker is bound
`default_nettype none
module agc_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// harness
	// ----
	logic mclk = 0, reset = 1, clock_loop_enable = 0, fs_tick = 0, short_detect = 0, handset_selected = 0;
	logic [7:0] agc_gain_code = 0, sidetone_target = 0, cellphone_target = 0;
	logic [3:0] buzzer_target = 0;
	agc_pkg::agc_req_t req;
	agc_pkg::agc_bias_t headset_bias_output;
	logic [15:0] rdata, q[$];
	logic rvalid, mic_gain_step_disable, conv_out_gain_step_disable, handset_bias_output, handset_input_mute;
	logic handset_agc_enable, agc_hysteresis_on;
	logic [13:0] pll_fraction_applied;
	logic [7:0] sidetone_gain_applied, cellphone_gain_applied;
	logic [3:0] buzzer_gain_applied;
	logic [2:0] agc_hysteresis_db;
	logic [6:0] handset_input_gain;
	int n_fail = 0, checked = 0, cyc = 0, seed = 53977;
	always #2 mclk = ~mclk;
	agc_host agc_host_inst (.mclk, .req);
	agc_regs agc_regs_inst (.mclk, .reset, .req, .rdata, .rvalid, .clock_loop_enable, .fs_tick, .short_detect,
		.handset_selected, .agc_gain_code, .sidetone_target, .cellphone_target, .buzzer_target, .pll_fraction_applied,
		.mic_gain_step_disable, .conv_out_gain_step_disable, .sidetone_gain_applied, .cellphone_gain_applied,
		.buzzer_gain_applied, .agc_hysteresis_db, .agc_hysteresis_on, .headset_bias_output, .handset_bias_output,
		.handset_input_mute, .handset_input_gain, .handset_agc_target(), .handset_agc_timing(), .handset_agc_enable);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic rd_exp(input logic [7:0] a, input logic [15:0] e);
		q.push_back(e);
		agc_host_inst.rd(a);
	endtask
	// outputs move two edges after the write edge
	task automatic settle;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic final_report;
		$display("counts: %0d checked, %0d failed", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 3000) begin
			n_fail++;
			final_report;
		end else if (rvalid === 1'b1) begin
			chk(rdata, q.pop_front(), "read data");
		end
	end
	// ----
	// scenarios
	// ----
	initial begin
		repeat (3) @(posedge mclk);
		reset <= 0;
		rd_exp(8'h1c, 16'h0000);
		rd_exp(8'h1d, 16'h0000);
		rd_exp(8'h1e, 16'hff00);
		$display("test reset done");
		@(posedge mclk) clock_loop_enable <= 1;
		agc_host_inst.wr(8'h1c, 16'hffff, 1);
		settle;
		chk(16'(pll_fraction_applied), 16'd9999, "clamp");
		rd_exp(8'h1c, 16'h9c3c);
		@(posedge mclk) clock_loop_enable <= 0;
		settle;
		chk(16'(pll_fraction_applied), 16'h0000, "loop off");
		$display("test fraction done");
		@(posedge mclk) begin
			sidetone_target <= {2'h0, 6'($random(seed))} | 8'h01;
			cellphone_target <= {2'h0, 6'($random(seed))} | 8'h01;
			buzzer_target <= 4'hf;
		end
		settle;
		chk(16'(sidetone_gain_applied), 16'h0000, "no tick");
		@(posedge mclk) fs_tick <= 1;
		@(posedge mclk) fs_tick <= 0;
		settle;
		chk(16'(sidetone_gain_applied), 16'h0001, "sidetone step");
		chk(16'(cellphone_gain_applied), 16'h0001, "cellphone step");
		chk(16'(buzzer_gain_applied), 16'h0001, "buzzer step");
		agc_host_inst.wr(8'h1d, 16'h3800, 0);
		settle;
		chk(16'(sidetone_gain_applied), 16'(sidetone_target), "sidetone jump");
		chk(16'(cellphone_gain_applied), 16'(cellphone_target), "cellphone jump");
		chk(16'(buzzer_gain_applied), 16'(buzzer_target), "buzzer jump");
		$display("test stepping done");
		@(posedge mclk) short_detect <= 1;
		for (int i = 0; i < 4; i++) begin
			logic [15:0] d;
			d = {i[0], i[1], 3'h0, i[1:0], i[1:0], i[0], 6'h3f};
			agc_host_inst.wr(8'h1d, d, 1);
			settle;
			chk(16'({mic_gain_step_disable, conv_out_gain_step_disable, handset_bias_output}),
				16'({i[0], i[1], i[0]}), "step bits");
			chk(16'(agc_hysteresis_db), i == 3 ? 16'h0 : 16'h1 << i, "hysteresis");
			chk(16'(headset_bias_output), i == 3 ? 16'h2 : 16'(i), "headset bias");
			chk(16'(agc_hysteresis_on), 16'h0000, "hysteresis without agc");
			rd_exp(8'h1d, {d[15:6], 6'h02});
		end
		$display("test control done");
		agc_host_inst.wr(8'h1e, 16'h2aae, 0);
		settle;
		chk(16'({handset_input_mute, handset_input_gain, handset_agc_enable}), 16'h0054, "manual");
		rd_exp(8'h1e, 16'h2aae);
		@(posedge mclk) begin
			handset_selected <= 1;
			agc_gain_code <= 8'he8;
		end
		agc_host_inst.wr(8'h1e, 16'haaaf, 0);
		settle;
		chk(16'({handset_input_mute, handset_agc_enable}), 16'h0001, "agc on");
		rd_exp(8'h1e, 16'he8af);
		chk(16'(agc_hysteresis_on), 16'h0000, "no hysteresis code");
		agc_host_inst.wr(8'h1d, 16'h0000, 0);
		settle;
		chk(16'(agc_hysteresis_on), 16'h0001, "hysteresis with agc");
		repeat (5) @(posedge mclk);
		$display("test handset done");
		final_report;
	end
endmodule
`default_nettype wire
